//--- hdl/scd_defines.svh
// Register offsets, field positions, reset codes and timing counts of the
// system clock divider. Assumes it is included by bare name, once or more.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// ****************************************************************
// Register map, byte addresses on the AXI4-Lite slave.
// ****************************************************************
`define SCD_ADDR_W 4
`define SCD_OFF_RC_TRIM 4'h0
`define SCD_OFF_DIV_CTRL 4'h4

// ****************************************************************
// Field layout of clock_divider_control and rc_trim.
// ****************************************************************
`define SCD_UNLOCK_BIT 7
`define SCD_SEL_MSB 3
`define SCD_TRIM_RANGE_BIT 7
`define SCD_TRIM_FINE_MSB 6

// ****************************************************************
// Reset codes of divider_select and the bus answer codes.
// ****************************************************************
`define SCD_SEL_RESET_PLAIN 4'h0
`define SCD_SEL_RESET_DIV8 4'h3
`define SCD_SEL_MAX 4'h8
`define SCD_RESP_OKAY 2'h0
`define SCD_RESP_DECERR 2'h3

// ****************************************************************
// Timing: unlock window in divided clock cycles, source clock period.
// ****************************************************************
`define SCD_UNLOCK_CYCLES 3'h4
`define SCD_CLK_PERIOD_NS 100

`endif

//--- hdl/scd_pkg.sv
// Types shared by the system clock divider files.
// Assumes nothing beyond a SystemVerilog compiler.
package scd_pkg;

	// ****************************************************************
	// Division switch sequencer states, one bit apart on each step except SCD_SW_WAIT_NEW back to SCD_SW_IDLE.
	// ****************************************************************
	typedef enum logic [1:0] {
		SCD_SW_IDLE = 2'b00,
		SCD_SW_WAIT_OLD = 2'b01,
		SCD_SW_WAIT_NEW = 2'b11
	} scd_switch_e;

	typedef logic [3:0] scd_sel_t;

endpackage

//--- hdl/scd_ripple.sv
// Divider counter of the system clock divider.
// Assumes clk_i is the undivided source clock and ce_i its global enable.
`include "scd_defines.svh"

module scd_ripple (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire scd_pkg::scd_sel_t sel_i,
	input wire logic restart_i,
	output logic tick_o
);

	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [7:0] mask;

	// Low n bits set for code n; reserved codes act as the largest factor.
	function automatic logic [7:0] scd_mask(input scd_pkg::scd_sel_t sel);
		logic [8:0] full;
		full = 9'h001;
		if (sel > `SCD_SEL_MAX) begin
			full = 9'h100;
		end else begin
			full = 9'h001 << sel;
		end
		return full[7:0] - 8'h01;
	endfunction

	// The count is private: software never sees it.
	assign mask = scd_mask(sel_i);
	assign tick_o = (count_reg & mask) == mask;
	assign count_next = restart_i ? 8'h00 : count_reg + 8'h01;

	// Runs at the undivided rate, one step per source cycle.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_reg <= 8'h00;
		end else if (ce_i) begin
			count_reg <= count_next;
		end
	end

endmodule

//--- hdl/scd_top.sv
// System clock divider with unlock-protected control and RC trim register.
// Assumes clk_i is the undivided master clock, and that the consumers of
// clk_en_o clock CPU, I/O, ADC and flash logic on its high cycles.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`include "scd_defines.svh"

module scd_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic start_divide_by_eight_fuse_i,
	input wire logic [7:0] factory_trim_i,
	input wire logic [`SCD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`SCD_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic clk_en_o,
	output logic trim_range_bit_o,
	output logic [6:0] trim_fine_bits_o
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] rc_trim_reg;
	logic divider_change_unlock_reg;
	logic divider_change_unlock_next;
	logic [2:0] unlock_timer_reg;
	logic [2:0] unlock_timer_next;
	scd_pkg::scd_sel_t divider_select_reg;
	scd_pkg::scd_sel_t active_sel_reg;
	scd_pkg::scd_switch_e state_reg;
	scd_pkg::scd_switch_e state_next;
	logic clk_en_reg;
	logic wr_go;
	logic wr_fire;
	logic rd_go;
	logic rd_fire;
	logic wr_trim;
	logic wr_ctrl;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] wbyte;
	logic unlock_req;
	logic sel_write;
	logic timeout;
	logic tick;
	logic restart;
	logic [7:0] ctrl_view;
	logic [31:0] rd_word;

	// ****************************************************************
	// AXI4-Lite handshakes.
	// ****************************************************************

	// Address and data are taken together, one write at a time, so the
	// write effect and the response never race each other.
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
	assign wr_fire = awready_reg && s_axi_awvalid && s_axi_wvalid;
	assign rd_go = s_axi_arvalid && !arready_reg && !rvalid_reg;
	assign rd_fire = arready_reg && s_axi_arvalid;
	assign wbyte = s_axi_wdata[7:0];
	assign wr_trim = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == `SCD_OFF_RC_TRIM);
	assign wr_ctrl = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == `SCD_OFF_DIV_CTRL);
	assign wr_hit = (s_axi_awaddr == `SCD_OFF_RC_TRIM) || (s_axi_awaddr == `SCD_OFF_DIV_CTRL);
	assign rd_hit = (s_axi_araddr == `SCD_OFF_RC_TRIM) || (s_axi_araddr == `SCD_OFF_DIV_CTRL);

	// Write channel: ready pulses for one cycle, response follows.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `SCD_RESP_OKAY;
		end else if (ce_i) begin
			awready_reg <= wr_go;
			wready_reg <= wr_go;
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `SCD_RESP_OKAY : `SCD_RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read view of the control register; the counter is not exposed.
	assign ctrl_view = {divider_change_unlock_reg, 3'b000, divider_select_reg};
	assign rd_word = (s_axi_araddr == `SCD_OFF_RC_TRIM) ? {24'h000000, rc_trim_reg} :
		(s_axi_araddr == `SCD_OFF_DIV_CTRL) ? {24'h000000, ctrl_view} : 32'h00000000;

	// Read channel: data sampled when the address is taken.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= `SCD_RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else if (ce_i) begin
			arready_reg <= rd_go;
			if (rd_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_word;
				rresp_reg <= rd_hit ? `SCD_RESP_OKAY : `SCD_RESP_DECERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// RC oscillator trim.
	// ****************************************************************

	// Factory value at reset, then free for software to retune.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rc_trim_reg <= factory_trim_i;
		end else if (ce_i && wr_trim) begin
			rc_trim_reg <= wbyte;
		end
	end

	// ****************************************************************
	// Unlock window.
	// ****************************************************************

	// Unlock request needs every other bit zero; a select write needs bit 7
	// low. A write with bit 7 high and other bits set does nothing at all.
	assign unlock_req = wr_ctrl && (wbyte == 8'h80);
	assign sel_write = wr_ctrl && !wbyte[`SCD_UNLOCK_BIT] && divider_change_unlock_reg;
	// The window is counted in divided cycles, the rate software runs at.
	assign timeout = divider_change_unlock_reg && tick && (unlock_timer_reg == 3'h1);

	// A select write closes the window at once; a repeat unlock while open
	// leaves the timer alone so the window cannot be stretched.
	always_comb begin
		divider_change_unlock_next = divider_change_unlock_reg;
		unlock_timer_next = unlock_timer_reg;
		if (sel_write || timeout) begin
			divider_change_unlock_next = 1'b0;
			unlock_timer_next = 3'h0;
		end else if (unlock_req && !divider_change_unlock_reg) begin
			divider_change_unlock_next = 1'b1;
			unlock_timer_next = `SCD_UNLOCK_CYCLES;
		end else if (divider_change_unlock_reg && tick) begin
			unlock_timer_next = unlock_timer_reg - 3'h1;
		end
	end

	// Holds the unlock flag, its timer and the written select.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			divider_change_unlock_reg <= 1'b0;
			unlock_timer_reg <= 3'h0;
			divider_select_reg <= start_divide_by_eight_fuse_i ?
				`SCD_SEL_RESET_DIV8 : `SCD_SEL_RESET_PLAIN;
		end else if (ce_i) begin
			divider_change_unlock_reg <= divider_change_unlock_next;
			unlock_timer_reg <= unlock_timer_next;
			if (sel_write) begin
				divider_select_reg <= wbyte[`SCD_SEL_MSB:0];
			end
		end
	end

	// ****************************************************************
	// Glitch-free division switch.
	// ****************************************************************

	// The old period is always finished first, then the counter restarts
	// under the new code, so no period is shorter than either.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			scd_pkg::SCD_SW_IDLE: begin
				if (sel_write) begin
					state_next = scd_pkg::SCD_SW_WAIT_OLD;
				end
			end
			scd_pkg::SCD_SW_WAIT_OLD: begin
				if (tick) begin
					state_next = scd_pkg::SCD_SW_WAIT_NEW;
				end
			end
			scd_pkg::SCD_SW_WAIT_NEW: begin
				if (sel_write) begin
					state_next = scd_pkg::SCD_SW_WAIT_OLD;
				end else if (tick) begin
					state_next = scd_pkg::SCD_SW_IDLE;
				end
			end
			default: begin
				state_next = scd_pkg::SCD_SW_IDLE;
			end
		endcase
	end

	// The new code takes over on the last old edge; a select written in that
	// same cycle goes straight in, so it can never be lost behind the switch.
	assign restart = (state_reg == scd_pkg::SCD_SW_WAIT_OLD) && tick;

	// Sequencer state, active code and the divided enable.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= scd_pkg::SCD_SW_IDLE;
			active_sel_reg <= start_divide_by_eight_fuse_i ?
				`SCD_SEL_RESET_DIV8 : `SCD_SEL_RESET_PLAIN;
			clk_en_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			if (restart) begin
				active_sel_reg <= sel_write ? wbyte[`SCD_SEL_MSB:0] : divider_select_reg;
			end
			clk_en_reg <= tick;
		end
	end

	scd_ripple u_ripple (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.sel_i(active_sel_reg),
		.restart_i(restart),
		.tick_o(tick)
	);

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign clk_en_o = clk_en_reg;
	// Range bit and fine bits are split straight from the trim flops.
	assign trim_range_bit_o = rc_trim_reg[`SCD_TRIM_RANGE_BIT];
	assign trim_fine_bits_o = rc_trim_reg[`SCD_TRIM_FINE_MSB:0];

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence old_edge_s;
		(state_reg == scd_pkg::SCD_SW_WAIT_OLD) && tick && ce_i;
	endsequence

	sequence new_edge_s;
		(state_reg == scd_pkg::SCD_SW_WAIT_NEW) && tick && ce_i && !sel_write;
	endsequence

	reserved_zero_a: assert property (rd_fire && ce_i && s_axi_araddr == `SCD_OFF_DIV_CTRL
		|=> s_axi_rdata[6:4] == 3'b000)
		else $error("reserved divider bits read nonzero");

	locked_ignore_a: assert property (wr_ctrl && ce_i && !divider_change_unlock_reg
		|=> $stable(divider_select_reg))
		else $error("select changed without unlock");

	unlock_clean_a: assert property ($rose(divider_change_unlock_reg)
		|-> $past(unlock_req && ce_i))
		else $error("unlock set by unclean write");

	unlock_timeout_a: assert property ($rose(divider_change_unlock_reg)
		|-> unlock_timer_reg == 3'h4)
		else $error("unlock window not four cycles");

	unlock_close_a: assert property (sel_write && ce_i |=> !divider_change_unlock_reg)
		else $error("unlock not cleared by select write");

	no_extend_a: assert property (divider_change_unlock_reg && unlock_req && ce_i && !timeout
		|=> unlock_timer_reg == $past(unlock_timer_reg) - {2'b00, $past(tick)})
		else $error("repeat unlock changed window");

	switch_edges_a: assert property (new_edge_s |=> state_reg == scd_pkg::SCD_SW_IDLE
		&& $stable(active_sel_reg)) else $error("switch did not end after two edges");

	switch_adopt_a: assert property (old_edge_s |=> clk_en_o
		&& active_sel_reg == divider_select_reg)
		else $error("new code not adopted on old edge");

	reset_sel_a: assert property ($past(!rst_n_i) |-> active_sel_reg ==
		($past(start_divide_by_eight_fuse_i) ? `SCD_SEL_RESET_DIV8 : `SCD_SEL_RESET_PLAIN))
		else $error("reset select wrong");

	trim_reset_a: assert property ($past(!rst_n_i) |-> rc_trim_reg == $past(factory_trim_i))
		else $error("trim not loaded at reset");

	undivided_a: assert property (active_sel_reg == 4'h0 && ce_i && $past(ce_i)
		&& state_reg == scd_pkg::SCD_SW_IDLE |-> tick)
		else $error("factor one does not tick every cycle");
endmodule

//--- bench/system_clock_divider_test.sv
// Self-checking bench for the system clock divider top, driven over AXI4-Lite.
// Assumes the design files and scd_defines.svh are compiled before this file.
`include "scd_defines.svh"

module system_clock_divider_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic fuse = 1'b1;
	logic [7:0] ftrim = 8'hA5;
	logic [3:0] s_axi_awaddr = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic clk_en_o;
	logic trim_range_bit_o;
	logic [6:0] trim_fine_bits_o;
	int error_cnt = 0;
	int comparisons = 0;
	int old_n = 5;
	int gap;

	// Half period of 50 ns gives the 10 MHz master clock.
	always #50 clk_i = ~clk_i;

	scd_top i_dut (
		.clk_i, .rst_n_i, .ce_i,
		.start_divide_by_eight_fuse_i(fuse),
		.factory_trim_i(ftrim),
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.clk_en_o, .trim_range_bit_o, .trim_fine_bits_o
	);

	// ****************************************************************
	// Compare, bus and timing tasks.
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Address and data go out together; each valid drops once its own ready is seen.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		chk("bvalid", 1, s_axi_bvalid);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		chk("rvalid", 1, s_axi_rvalid);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		chk("rdata", ed, s_axi_rdata);
	endtask

	// Counts edges until the divided enable is seen high; bounded so a dead divider cannot hang.
	task automatic pulse(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (clk_en_o !== 1'b1 && n < 2000);
		chk("clk_en_o", 1, clk_en_o);
	endtask

	task automatic pulses(input int k);
		int g;
		repeat (k) pulse(g);
	endtask

	// Unlock, select code n, then wait for two gaps of the new period in a row.
	task automatic set_div(input int n);
		int t1, t2, g, prev, tot, mn, k;
		t1 = 1 << old_n;
		t2 = 1 << n;
		mn = (t1 < t2) ? t1 : t2;
		prev = 0;
		tot = 0;
		// No other traffic sits between the two writes, as with interrupts masked.
		wr(`SCD_OFF_DIV_CTRL, 32'h80, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, n, `SCD_RESP_OKAY);
		for (k = 0; k < 8 && !(prev == t2 && g == t2); k++) begin
			prev = (k == 0) ? 0 : g;
			pulse(g);
			tot += g;
			if (k > 0)
				chk("gap_not_short", 1, g >= mn);
		end
		chk("steady_gap", t2, g);
		chk("switch_time_ok", 1, tot <= t1 + 3 * t2 + 4);
		old_n = n;
	endtask

	task automatic do_reset(input logic f, input logic [7:0] t);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		fuse <= f;
		ftrim <= t;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial begin
		do_reset(1'b1, 8'hA5);
		rd(`SCD_OFF_RC_TRIM, 32'hA5, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h03, `SCD_RESP_OKAY);
		wr(`SCD_OFF_RC_TRIM, 32'hC2, `SCD_RESP_OKAY);
		rd(`SCD_OFF_RC_TRIM, 32'hC2, `SCD_RESP_OKAY);
		chk("trim_range", 1, trim_range_bit_o);
		chk("trim_fine", 32'h42, trim_fine_bits_o);
		wr(`SCD_OFF_DIV_CTRL, 32'h01, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h03, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, 32'h81, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, 32'h01, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h03, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, 32'h80, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h83, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, 32'h75, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h05, `SCD_RESP_OKAY);
		pulses(3);
		// A rewrite of the unlock pattern mid-window must not restart the count.
		wr(`SCD_OFF_DIV_CTRL, 32'h80, `SCD_RESP_OKAY);
		pulses(3);
		wr(`SCD_OFF_DIV_CTRL, 32'h80, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h85, `SCD_RESP_OKAY);
		pulses(2);
		rd(`SCD_OFF_DIV_CTRL, 32'h05, `SCD_RESP_OKAY);
		wr(`SCD_OFF_DIV_CTRL, 32'h01, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h05, `SCD_RESP_OKAY);
		// Freezing the enable for 40 cycles must stretch one divide-by-32 gap by 40.
		pulse(gap);
		ce_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk("frozen_en", 0, clk_en_o);
		ce_i <= 1'b1;
		pulse(gap);
		chk("freeze_gap", 32, gap);
		for (int n = 0; n <= 8; n++)
			set_div(n);
		wr(4'h8, 32'h11, `SCD_RESP_DECERR);
		rd(4'hC, 32'h0, `SCD_RESP_DECERR);
		do_reset(1'b0, 8'h3C);
		rd(`SCD_OFF_RC_TRIM, 32'h3C, `SCD_RESP_OKAY);
		rd(`SCD_OFF_DIV_CTRL, 32'h00, `SCD_RESP_OKAY);
		chk("trim_range", 0, trim_range_bit_o);
		chk("trim_fine", 32'h3C, trim_fine_bits_o);
		print_verdict();
	end

	// The tests take about 2000 cycles; ten times that means the bench hung.
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		print_verdict();
	end

endmodule
